// ===== verilog/idm_top.sv
// Internal data memory: 256-byte space, 192 bytes populated, bit window.
// Assumes the CPU holds a request for one cycle and waits for rd_valid.
// What this block does
// RQ1: Serves a 256-byte internal RAM space and flags a separate 128-entry special space.
// RQ2: Maps four banks of eight working registers onto bytes 0 to 31.
// RQ3: Gives 128 addressable bits stored in bytes 32 to 47, still byte-reachable.
// RQ4: Lets the stack pointer reach any location of the space without restriction; above 191 writes are dropped and reads return FF.
// RQ5: Backs addresses 0 to 191 with storage and leaves higher ones unpopulated.
// RQ6: Holds 64 bytes beyond the base core's 128, 192 bytes in all.
// RQ7: Maps bit address b below 128 to byte 32 plus b/8, bit b mod 8.
`timescale 1ns/1ps
`default_nettype none
module idm_top
    import idm_pkg::*;
(
    input  wire logic                  clk_sys,      // Core clock, 125 MHz
    input  wire logic                  rst_n,        // Async reset, active low
    input  wire logic                  byte_rd,      // Byte read request
    input  wire logic                  byte_wr,      // Byte write request
    input  wire logic                  sfr_sel,      // Address targets special space
    input  wire logic                  stack_acc,    // Access made through stack pointer
    input  wire logic [IDM_ADDR_W-1:0] byte_addr,    // Byte address
    input  wire logic [IDM_DATA_W-1:0] byte_wdata,   // Byte write data
    input  wire logic [1:0]            bank_sel,     // Active register bank
    input  wire logic                  reg_rd,       // Working register read
    input  wire logic                  reg_wr,       // Working register write
    input  wire logic [2:0]            reg_num,      // Working register number
    input  wire logic                  bit_rd,       // Bit read request
    input  wire logic                  bit_wr,       // Bit write request
    input  wire logic [6:0]            bit_addr,     // Bit address below 128
    input  wire logic                  bit_wdata,    // Bit write value
    output logic                       rd_valid,     // Read answer pulse
    output logic      [IDM_DATA_W-1:0] rd_data,      // Read byte
    output logic                       rd_bit,       // Read bit
    output logic                       sfr_req,      // Passed-on special-space access
    output logic                       unpop_hit,    // Access fell above 191
    output logic                       busy          // Bit write in progress
);
    // RQ7: bit to byte translation
    function automatic logic [7:0] bit_to_byte(input logic [6:0] b);
        return IDM_BIT_FIRST + {4'h0, b[6:3]};
    endfunction

    // RQ5: populated range check
    function automatic logic is_pop(input logic [7:0] a);
        return a <= IDM_PHYS_LAST;
    endfunction

    idm_state_t           state_reg;
    logic [7:0]           mod_addr_reg;
    logic [2:0]           mod_bit_reg;
    logic                 mod_val_reg;
    logic                 pend_rd_reg;
    logic                 pend_bit_reg;
    logic                 pend_pop_reg;
    logic [2:0]           pend_sel_reg;
    logic                 ram_we;
    logic [7:0]           ram_waddr;
    logic [7:0]           ram_wdata;
    logic [7:0]           ram_raddr;
    logic [7:0]           ram_rdata;
    logic [7:0]           reg_addr;
    logic [7:0]           acc_addr;
    logic                 acc_rd;
    logic                 acc_wr;
    logic [7:0]           merged;
    logic                 idle_now;
    logic                 bit_req;
    logic                 reg_req;
    logic                 byte_req;
    logic                 bit_wr_take;
    logic                 sfr_take;

    // Requests are only looked at outside the modify cycle
    assign idle_now    = state_reg == IDM_IDLE;
    assign bit_req     = bit_rd || bit_wr;
    assign reg_req     = reg_rd || reg_wr;
    assign byte_req    = byte_rd || byte_wr;
    assign bit_wr_take = idle_now && bit_wr;

    // RQ1: special byte access that wins arbitration
    assign sfr_take = idle_now && sfr_sel && !stack_acc && byte_req && !bit_req && !reg_req;

    // RQ2: bank times eight plus register
    assign reg_addr = {3'h0, bank_sel, reg_num};

    // RQ4: stack accesses use the full byte address
    always_comb begin
        acc_addr = byte_addr;
        acc_rd   = 1'b0;
        acc_wr   = 1'b0;
        if (idle_now) begin
            if (bit_req) begin
                acc_addr = bit_to_byte(bit_addr);
                acc_rd   = 1'b1;
            end else if (reg_req) begin
                acc_addr = reg_addr;
                acc_rd   = reg_rd;
                acc_wr   = reg_wr;
            end else if (!sfr_sel || stack_acc) begin
                acc_addr = byte_addr;
                acc_rd   = byte_rd;
                acc_wr   = byte_wr;
            end
        end
    end

    // RQ3: read-modify-write of the selected bit
    always_comb begin
        merged = ram_rdata;
        merged[mod_bit_reg] = mod_val_reg;
    end

    // RQ5: writes above the populated range are dropped
    always_comb begin
        if (state_reg == IDM_BIT_MODIFY) begin
            ram_we    = 1'b1;
            ram_waddr = mod_addr_reg;
            ram_wdata = merged;
        end else begin
            ram_we    = acc_wr && is_pop(acc_addr);
            ram_waddr = acc_addr;
            ram_wdata = byte_wdata;
        end
    end
    assign ram_raddr = acc_addr;

    // RQ6: 192-byte physical array
    idm_ram u_ram (
        .clk_sys (clk_sys),
        .we      (ram_we),
        .waddr   (ram_waddr),
        .wdata   (ram_wdata),
        .raddr   (ram_raddr),
        .rdata   (ram_rdata)
    );

    // RQ3: bit write needs a second cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg    <= IDM_IDLE;
            mod_addr_reg <= IDM_RESET_BYTE;
            mod_bit_reg  <= 3'h0;
            mod_val_reg  <= 1'b0;
        end else begin
            unique case (state_reg)
                IDM_IDLE: begin
                    if (bit_wr) begin
                        state_reg    <= IDM_BIT_MODIFY;
                        mod_addr_reg <= bit_to_byte(bit_addr);
                        mod_bit_reg  <= bit_addr[2:0];
                        mod_val_reg  <= bit_wdata;
                    end
                end
                IDM_BIT_MODIFY: begin
                    state_reg <= IDM_IDLE;
                end
            endcase
        end
    end

    // Bit write reads its byte but gives no answer
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pend_rd_reg  <= 1'b0;
            pend_bit_reg <= 1'b0;
        end else begin
            pend_rd_reg  <= acc_rd && !bit_wr_take;
            pend_bit_reg <= bit_rd && idle_now;
        end
    end

    // RQ7: bit position travels with the read
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pend_pop_reg <= 1'b0;
            pend_sel_reg <= 3'h0;
        end else begin
            pend_pop_reg <= is_pop(acc_addr);
            pend_sel_reg <= bit_addr[2:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= pend_rd_reg;
        end
    end

    // RQ5: unpopulated reads return a fixed value
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_data  <= IDM_RESET_BYTE;
            rd_bit   <= 1'b0;
        end else begin
            if (pend_rd_reg) begin
                rd_data <= pend_pop_reg ? ram_rdata : IDM_UNPOP_READ;
                rd_bit  <= pend_bit_reg ? ram_rdata[pend_sel_reg] : 1'b0;
            end
        end
    end

    // RQ1: special space is not stored here
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sfr_req <= 1'b0;
        end else begin
            sfr_req <= sfr_take;
        end
    end

    // RQ5: access above the populated range
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            unpop_hit <= 1'b0;
        end else begin
            unpop_hit <= (acc_rd || acc_wr) && !is_pop(acc_addr);
        end
    end

    // RQ3: modify cycle, requests ignored
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
        end else begin
            busy <= bit_wr_take;
        end
    end
endmodule
`default_nettype wire

// ===== verilog/idm_pkg.sv
// Constants for the internal data memory map of the 8-bit core.
// Assumes a single core clock and one CPU-side access port.
package idm_pkg;
    localparam int unsigned IDM_ADDR_W     = 8;
    localparam int unsigned IDM_DATA_W     = 8;
    localparam int unsigned IDM_SPACE_SIZE = 256;
    localparam int unsigned IDM_SFR_SIZE   = 128;
    localparam int unsigned IDM_BASE_BYTES = 128;
    localparam int unsigned IDM_EXTRA_BYTES = 64;
    localparam int unsigned IDM_PHYS_BYTES = IDM_BASE_BYTES + IDM_EXTRA_BYTES;
    localparam logic [7:0]  IDM_PHYS_LAST  = 8'hBF;
    localparam logic [7:0]  IDM_BANK_LAST  = 8'h1F;
    localparam int unsigned IDM_BANK_REGS  = 8;
    localparam int unsigned IDM_BANK_COUNT = 4;
    localparam logic [7:0]  IDM_BIT_FIRST  = 8'h20;
    localparam logic [7:0]  IDM_BIT_LAST   = 8'h2F;
    localparam int unsigned IDM_BIT_COUNT  = 128;
    localparam logic [7:0]  IDM_UNPOP_READ = 8'hFF;
    localparam logic [7:0]  IDM_RESET_BYTE = 8'h00;

    typedef enum logic [1:0] {
        IDM_IDLE,
        IDM_BIT_MODIFY
    } idm_state_t;
endpackage

// ===== verilog/idm_ram.sv
// Byte-wide storage array with a registered read port.
// Assumes one write or one read per cycle from the controller above it.
`timescale 1ns/1ps
`default_nettype none
module idm_ram
    import idm_pkg::*;
(
    input  wire logic                  clk_sys,  // Core clock
    input  wire logic                  we,       // Write strobe
    input  wire logic [IDM_ADDR_W-1:0] waddr,    // Write address
    input  wire logic [IDM_DATA_W-1:0] wdata,    // Write data
    input  wire logic [IDM_ADDR_W-1:0] raddr,    // Read address
    output logic      [IDM_DATA_W-1:0] rdata     // Registered read data
);
    logic [IDM_DATA_W-1:0] mem [IDM_PHYS_BYTES];

    // No reset on the array; content is undefined until written
    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

// ===== verification/idm_assertions.sv
// Port checker for idm_top.
// Assumes one core clock and binding from the bench.
`timescale 1ns/1ps
`default_nettype none
module idm_assertions
    import idm_pkg::*;
(
    input wire logic       clk_sys, rst_n, byte_rd, byte_wr, sfr_sel, // Clock, reset, byte
    input wire logic       stack_acc, reg_rd, reg_wr, bit_rd, bit_wr, // Other requests
    input wire logic [7:0] byte_addr, rd_data,                        // Address, read byte
    input wire logic [6:0] bit_addr,                                  // Bit address
    input wire logic       rd_valid, rd_bit, sfr_req, unpop_hit, busy // Answers
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Byte request that wins arbitration
    wire logic byte_go = (byte_rd | byte_wr) & ~(bit_rd | bit_wr | reg_rd | reg_wr | busy);
    wire logic to_sfr = sfr_sel & ~stack_acc;
    wire logic bit_go = bit_rd & ~bit_wr & ~busy;
    wire logic reg_go = reg_rd & ~(bit_rd | bit_wr | busy);
    reg_rd_a: assert property (reg_go |-> ##2 rd_valid && !rd_bit)
        else $error("register read lost");
    sfr_pass_a: assert property (byte_go && to_sfr |=> sfr_req)
        else $error("special access not passed on");
    sfr_local_a: assert property (byte_go && byte_rd && to_sfr |-> ##2 !rd_valid)
        else $error("special read answered here");
    unpop_flag_a: assert property (byte_go && !to_sfr
        |=> unpop_hit == ($past(byte_addr) > IDM_PHYS_LAST)) else $error("unpop flag wrong");
    unpop_read_a: assert property (byte_go && byte_rd && !to_sfr && byte_addr > 8'hBF
        |-> ##2 rd_valid && rd_data == IDM_UNPOP_READ) else $error("unpop read wrong");
    bit_lat_a: assert property (bit_go |-> ##2 rd_valid)
        else $error("bit read latency wrong");
    bit_sel_a: assert property (rd_valid && $past(bit_go, 2)
        |-> rd_bit == rd_data[3'($past(bit_addr, 2))]) else $error("bit position wrong");
    busy_one_a: assert property (bit_wr && !busy |=> busy ##1 !busy)
        else $error("modify cycle wrong");
    busy_ign_a: assert property (busy |-> ##2 !rd_valid)
        else $error("request taken while busy");
    stack_rd_a: assert property (byte_go && byte_rd && stack_acc
        |-> ##2 rd_valid && !rd_bit) else $error("stack read lost");
endmodule
`default_nettype wire

// ===== verification/idm_cpu_model.sv
// CPU-side request model, one request per clock edge.
// Assumes put and idle are called from one process.
`timescale 1ns/1ps
`default_nettype none
module idm_cpu_model (
    input  wire logic  clk_sys,                                     // Core clock
    output logic       byte_rd, byte_wr, sfr_sel, stack_acc,        // Byte requests
    output logic       reg_rd, reg_wr, bit_rd, bit_wr, bit_wdata,   // Reg and bit requests
    output logic [7:0] byte_addr, byte_wdata,                       // Byte address, data
    output logic [1:0] bank_sel,                                    // Active bank
    output logic [2:0] reg_num,                                     // Register number
    output logic [6:0] bit_addr                                     // Bit address
);
    initial begin
        {byte_rd, byte_wr, sfr_sel, stack_acc, reg_rd, reg_wr, bit_rd, bit_wr, bit_wdata} = '0;
        {byte_addr, byte_wdata, bank_sel, reg_num, bit_addr} = '0;
    end
    // Kind 0 byte, 1 reg, 2 bit, 3 special, 4 stack
    task automatic put(input int k, input logic w, input logic [7:0] a, d);
        @(posedge clk_sys);
        byte_rd <= (k == 0 || k > 2) && !w;
        byte_wr <= (k == 0 || k > 2) && w;
        sfr_sel <= k > 2;
        stack_acc <= k == 4;
        {reg_rd, reg_wr} <= {k == 1 && !w, k == 1 && w};
        {bit_rd, bit_wr} <= {k == 2 && !w, k == 2 && w};
        {byte_addr, byte_wdata, bit_wdata} <= {a, d, d[0]};
        {bank_sel, reg_num, bit_addr} <= {a[4:0], a[6:0]};
    endtask
    // Released lines invert so stale values never match
    task automatic idle();
        @(posedge clk_sys);
        {byte_rd, byte_wr, reg_rd, reg_wr, bit_rd, bit_wr} <= '0;
        {byte_addr, byte_wdata, bit_addr} <= ~{byte_addr, byte_wdata, bit_addr};
    endtask
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// Bench for idm_top with a CPU request model.
// Assumes the checker is bound below.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import idm_pkg::*;
    logic clk_sys = 1'b0, rst_n = 1'b0;
    logic byte_rd, byte_wr, sfr_sel, stack_acc, reg_rd, reg_wr, bit_rd, bit_wr, bit_wdata;
    logic [7:0] byte_addr, byte_wdata, rd_data, m[16];
    logic [1:0] bank_sel;
    logic [2:0] reg_num;
    logic [6:0] bit_addr;
    logic rd_valid, rd_bit, sfr_req, unpop_hit, busy;
    logic [8:0] q[$];
    int failures = 0, samples_checked = 0, sfr_cnt = 0;
    always #4 clk_sys = ~clk_sys;
    idm_top i_dut (.clk_sys, .rst_n, .byte_rd, .byte_wr, .sfr_sel, .stack_acc, .byte_addr,
        .byte_wdata, .bank_sel, .reg_rd, .reg_wr, .reg_num, .bit_rd, .bit_wr, .bit_addr,
        .bit_wdata, .rd_valid, .rd_data, .rd_bit, .sfr_req, .unpop_hit, .busy);
    idm_cpu_model i_cpu (.clk_sys, .byte_rd, .byte_wr, .sfr_sel, .stack_acc, .reg_rd,
        .reg_wr, .bit_rd, .bit_wr, .bit_wdata, .byte_addr, .byte_wdata, .bank_sel, .reg_num,
        .bit_addr);
    always @(posedge clk_sys) begin
        if (rd_valid === 1'b1) q.push_back({rd_bit, rd_data});
        if (sfr_req === 1'b1) sfr_cnt++;
    end
    task automatic cmp(input logic [8:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic get(input logic [8:0] exp);
        logic [8:0] v = 'x;
        for (int i = 0; i < 8 && q.size() == 0; i++) @(negedge clk_sys);
        if (q.size() != 0) v = q.pop_front();
        cmp(v, exp);
    endtask
    task automatic t_space();
        for (int a = 0; a < 256; a++) i_cpu.put(0, 1, 8'(a), 8'(a) ^ 8'h5A);
        for (int a = 0; a < 256; a++) i_cpu.put(0, 0, 8'(a), 8'h00);
        i_cpu.idle();
        for (int a = 0; a < 256; a++)
            get({1'b0, (a > 191) ? 8'hFF : 8'(a) ^ 8'h5A});
        $display("space test done");
    endtask
    task automatic t_bank();
        for (int a = 0; a < 32; a++) begin
            i_cpu.put(1, 1, 8'(a), 8'(a) ^ 8'hC3);
            i_cpu.put(0, 0, 8'(a), 8'h00);
            i_cpu.put(1, 0, 8'(a), 8'h00);
        end
        i_cpu.idle();
        for (int a = 0; a < 64; a++) get({1'b0, 8'(a / 2) ^ 8'hC3});
        $display("bank test done");
    endtask
    task automatic t_bits();
        for (int i = 0; i < 16; i++) i_cpu.put(0, 1, 8'(32 + i), 8'h00);
        m = '{default: 8'h00};
        for (int b = 0; b < 128; b++) begin
            i_cpu.put(2, 1, 8'(b), 8'(b % 3 == 0));
            i_cpu.put(0, 0, 8'hB0, 8'h00);
            i_cpu.put(2, 0, 8'(b), 8'h00);
            i_cpu.idle();
            m[b / 8][b % 8] = (b % 3 == 0);
            get({1'(b % 3 == 0), m[b / 8]});
        end
        for (int i = 0; i < 16; i++) i_cpu.put(0, 0, 8'(32 + i), 8'h00);
        i_cpu.idle();
        for (int i = 0; i < 16; i++) get({1'b0, m[i]});
        $display("bit test done");
    endtask
    task automatic t_stack();
        i_cpu.put(4, 1, 8'hBF, 8'h3C);
        i_cpu.put(4, 0, 8'hBF, 8'h00);
        i_cpu.put(4, 0, 8'hF0, 8'h00);
        i_cpu.put(3, 0, 8'h90, 8'h00);
        i_cpu.idle();
        get(9'h03C);
        get(9'h0FF);
        repeat (4) @(negedge clk_sys);
        cmp(9'(q.size() + sfr_cnt), 9'h001);
        $display("stack test done");
    endtask
    task automatic summarize();
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_space();
        t_bank();
        t_bits();
        t_stack();
        summarize();
    end
    initial begin
        #100000;
        failures++;
        summarize();
    end
endmodule
bind idm_top idm_assertions i_chk (.clk_sys, .rst_n, .byte_rd, .byte_wr, .sfr_sel,
    .stack_acc, .reg_rd, .reg_wr, .bit_rd, .bit_wr, .byte_addr, .rd_data, .bit_addr,
    .rd_valid, .rd_bit, .sfr_req, .unpop_hit, .busy);
`default_nettype wire
